// ==== hw/sfc_pkg.sv ====
package sfc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_MODE   = 3'h0;
   localparam logic [2:0] ADDR_CTRL   = 3'h1;
   localparam logic [2:0] ADDR_RATE   = 3'h2;
   localparam logic [2:0] ADDR_PRESC  = 3'h3;
   localparam logic [2:0] ADDR_TXDATA = 3'h4;
   localparam logic [2:0] ADDR_RXDATA = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;

   // serial_mode_reg fields
   localparam int MODE_SYNC   = 7;
   localparam int MODE_CHAR7  = 6;
   localparam int MODE_PAR_EN = 5;
   localparam int MODE_ODD    = 4;
   localparam int MODE_STOP2  = 3;
   localparam int MODE_MP     = 2;
   localparam int MODE_PSC_HI = 1;
   localparam int MODE_PSC_LO = 0;

   // serial_control_reg fields
   localparam int CTRL_TX_EN  = 5;
   localparam int CTRL_RX_ON  = 4;
   localparam int CTRL_TX_MPB = 2;
   localparam int CTRL_CKSRC1 = 1;
   localparam int CTRL_CKSRC0 = 0;

   // status fields
   localparam int ST_TDR_EMPTY = 7;
   localparam int ST_RDR_FULL  = 6;
   localparam int ST_OVERRUN   = 5;
   localparam int ST_FRAMING   = 4;
   localparam int ST_PARITY    = 3;
   localparam int ST_TX_END    = 2;
   localparam int ST_RX_MPB    = 1;
   localparam int ST_BREAK     = 0;

   // reset values
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] RATE_RST   = 8'hFF;

   // 16x oversampling: mid-cell is the 8th tick (index 7)
   localparam logic [3:0] OVS_MID    = 4'h7;
   localparam logic [3:0] OVS_LAST   = 4'hF;
   localparam logic [3:0] SYNC_LAST  = 4'h7;

   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} sfc_tx_state_type;
   typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} sfc_rx_state_type;

   // last count of the prescaler for code n and doubling
   function automatic logic [6:0] sfc_pre_last(input logic [1:0] n, input logic dbl);
      case ({dbl, n})
         3'h1:    return 7'h03;
         3'h2:    return 7'h0F;
         3'h3:    return 7'h3F;
         3'h5:    return 7'h07;
         3'h6:    return 7'h1F;
         3'h7:    return 7'h7F;
         default: return 7'h00;
      endcase
   endfunction : sfc_pre_last

   function automatic logic sfc_parity(input logic [7:0] d, input logic char7, input logic odd);
      return (^d[6:0]) ^ (d[7] & ~char7) ^ odd;
   endfunction : sfc_parity

   // frame, lsb first: start, data, optional extra bit, stop bits (ones)
   function automatic logic [11:0] sfc_frame(input logic [7:0] d, input logic char7,
                                             input logic ext_en, input logic ext_bit);
      logic [11:0] f;
      f    = 12'hFFF;
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < 7 || !char7) begin
            f[i+1] = d[i];
         end
      end
      if (ext_en) begin
         f[char7 ? 4'h8 : 4'h9] = ext_bit;
      end
      return f;
   endfunction : sfc_frame

   function automatic logic [3:0] sfc_len(input logic char7, input logic ext_en,
                                          input logic stop2);
      return 4'hA - {3'h0, char7} + {3'h0, ext_en} + {3'h0, stop2};
   endfunction : sfc_len

endpackage : sfc_pkg

// ==== hw/sfc_link_if.sv ====
interface sfc_link_if;
   logic dev_txd;
   logic dev_sck;
   logic dev_sck_oe_n;
   logic par_txd;
   logic par_sck;
   logic par_sck_oe_n;
   logic sck;

   // resolved clock pin level, pulled high when nobody drives it
   assign sck = !dev_sck_oe_n ? dev_sck : (!par_sck_oe_n ? par_sck : 1'b1);

   modport device  (output dev_txd, dev_sck, dev_sck_oe_n, input par_txd, sck);
   modport partner (output par_txd, par_sck, par_sck_oe_n, input dev_txd, sck);
endinterface : sfc_link_if

// ==== hw/sfc_unit.sv ====
module sfc_unit
   import sfc_pkg::*;
(
   // system
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   // register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       wr_en_i,
   input  wire logic       rd_en_i,
   output logic [7:0]      rd_data_o,
   // serial link
   sfc_link_if.device      link
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       mode;
      logic [7:0]       ctrl;
      logic [7:0]       rate;
      logic             dbl;
      logic [7:0]       tdr;
      logic [7:0]       rdr;
      logic [7:0]       stat;
      logic [6:0]       pre;
      logic [7:0]       brg;
      logic             half;
      logic [2:0]       sck_sync;
      logic             sck_lvl;
      logic [2:0]       rxd_sync;
      logic             rxd_lvl;
      logic [3:0]       phase;
      logic             sck_int;
      sfc_tx_state_type tx_st;
      logic [11:0]      tsr;
      logic [3:0]       tx_cnt;
      sfc_rx_state_type rx_st;
      logic [11:0]      rsr;
      logic [3:0]       rx_cnt;
      logic [3:0]       rx_ph;
      logic             txd;
      logic             sck_o;
      logic             sck_oe_n;
      logic [7:0]       rdata;
   } sfc_dev_state_type;

   sfc_dev_state_type q;
   sfc_dev_state_type d;

   logic        sync_m;
   logic        ext_ck;
   logic        char7;
   logic        ext_en;
   logic        ext_bit;
   logic        pre_tick;
   logic        brg_tick;
   logic        half_tick;
   logic        ext_rise;
   logic        ext_fall;
   logic        rx_fall;
   logic        os_tick;
   logic        bit_end;
   logic        run;
   logic        s_rise;
   logic        s_fall;
   logic        tx_load;
   logic        rx_done;
   logic [11:0] rx_bits;
   logic [7:0]  rx_data;
   logic [3:0]  rx_last;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d       = q;
      d.rdata = 8'h00;
      sync_m  = q.mode[MODE_SYNC];
      ext_ck  = q.ctrl[CTRL_CKSRC1];
      char7   = q.mode[MODE_CHAR7] & ~sync_m;
      ext_en  = (q.mode[MODE_MP] | q.mode[MODE_PAR_EN]) & ~sync_m;
      ext_bit = q.mode[MODE_MP] ? q.ctrl[CTRL_TX_MPB]
                                : sfc_parity(q.tdr, char7, q.mode[MODE_ODD]);

      // register port writes; hardware sets further down win over clears
      if (wr_en_i) begin
         case (addr_i)
            ADDR_MODE:   d.mode = wr_data_i;
            ADDR_CTRL:   d.ctrl = wr_data_i;
            ADDR_RATE:   d.rate = wr_data_i;
            ADDR_PRESC:  d.dbl  = wr_data_i[0];
            ADDR_TXDATA: begin
               d.tdr                = wr_data_i;
               d.stat[ST_TDR_EMPTY] = 1'b0;
            end
            ADDR_STATUS: d.stat = q.stat & (wr_data_i | 8'h86);
            default:     d.stat = q.stat;
         endcase
      end
      if (rd_en_i) begin
         case (addr_i)
            ADDR_MODE:   d.rdata = q.mode;
            ADDR_CTRL:   d.rdata = q.ctrl;
            ADDR_RATE:   d.rdata = q.rate;
            ADDR_PRESC:  d.rdata = {7'h00, q.dbl};
            ADDR_TXDATA: d.rdata = q.tdr;
            ADDR_RXDATA: d.rdata = q.rdr;
            ADDR_STATUS: d.rdata = q.stat;
            default:     d.rdata = 8'h00;
         endcase
      end

      // baud generator: prescaler then N+1 divider, halted on external clock
      pre_tick  = (q.pre == sfc_pre_last(q.mode[MODE_PSC_HI:MODE_PSC_LO], q.dbl));
      brg_tick  = pre_tick & (q.brg == q.rate) & ~ext_ck;
      half_tick = brg_tick & q.half;
      d.pre     = (pre_tick | ext_ck) ? 7'h00 : q.pre + 7'h01;
      if (ext_ck) begin
         d.brg  = 8'h00;
         d.half = 1'b0;
      end else if (pre_tick) begin
         d.brg  = (q.brg == q.rate) ? 8'h00 : q.brg + 8'h01;
         d.half = brg_tick ? ~q.half : q.half;
      end

      // pin synchronisers; a level counts once stages two and three agree
      d.sck_sync = {q.sck_sync[1:0], link.sck};
      d.rxd_sync = {q.rxd_sync[1:0], link.par_txd};
      ext_rise   = (q.sck_sync[2] == q.sck_sync[1]) & q.sck_sync[2] & ~q.sck_lvl;
      ext_fall   = (q.sck_sync[2] == q.sck_sync[1]) & ~q.sck_sync[2] & q.sck_lvl;
      rx_fall    = (q.rxd_sync[2] == q.rxd_sync[1]) & ~q.rxd_sync[2] & q.rxd_lvl;
      if (q.sck_sync[2] == q.sck_sync[1]) begin
         d.sck_lvl = q.sck_sync[2];
      end
      if (q.rxd_sync[2] == q.rxd_sync[1]) begin
         d.rxd_lvl = q.rxd_sync[2];
      end

      // async 16x tick and bit phase
      os_tick = ext_ck ? ext_rise : half_tick;
      bit_end = os_tick & (q.phase == OVS_LAST) & ~sync_m;
      if (os_tick & ~sync_m) begin
         d.phase = q.phase + 4'h1;
      end

      // sync clock: internal toggles only while a character is moving
      run    = (q.tx_st == TX_SYNC) | (q.rx_st == RX_SYNC);
      s_fall = sync_m & (ext_ck ? ext_fall : (half_tick & run & q.sck_int));
      s_rise = sync_m & (ext_ck ? ext_rise : (half_tick & run & ~q.sck_int));
      if (!run) begin
         d.sck_int = 1'b1;
      end else if (half_tick) begin
         d.sck_int = ~q.sck_int;
      end

      // clock pin
      if (sync_m) begin
         d.sck_oe_n = ext_ck;
         d.sck_o    = q.sck_int;
      end else begin
         d.sck_oe_n = ext_ck | ~q.ctrl[CTRL_CKSRC0];
         d.sck_o    = q.phase[3];
      end

      // transmitter
      tx_load = 1'b0;
      case (q.tx_st)
         TX_IDLE: begin
            d.txd   = 1'b1;
            tx_load = sync_m | bit_end;
         end
         TX_ASYNC: begin
            if (bit_end) begin
               if (q.tx_cnt == 4'h0) begin
                  tx_load = 1'b1;
               end else begin
                  d.tsr    = {1'b1, q.tsr[11:1]};
                  d.txd    = q.tsr[1];
                  d.tx_cnt = q.tx_cnt - 4'h1;
               end
            end
         end
         TX_SYNC: begin
            if (s_rise & (q.tx_cnt == 4'h0)) begin
               tx_load = 1'b1;
            end else if (s_rise) begin
               d.tx_cnt = q.tx_cnt - 4'h1;
            end else if (s_fall & (q.tx_cnt != SYNC_LAST)) begin
               // the first fall keeps bit 0 on the line for the first rise
               d.tsr = {1'b1, q.tsr[11:1]};
               d.txd = q.tsr[1];
            end
         end
         default: d.tx_st = TX_IDLE;
      endcase
      // the buffered character follows the previous one without a gap
      if (tx_load) begin
         if (q.ctrl[CTRL_TX_EN] & ~q.stat[ST_TDR_EMPTY]) begin
            d.stat[ST_TDR_EMPTY] = 1'b1;
            d.stat[ST_TX_END]    = 1'b0;
            if (sync_m) begin
               d.tsr    = {4'hF, q.tdr};
               d.tx_cnt = SYNC_LAST;
               d.tx_st  = TX_SYNC;
               d.txd    = q.tdr[0];
            end else begin
               d.tsr    = sfc_frame(q.tdr, char7, ext_en, ext_bit);
               d.tx_cnt = sfc_len(char7, ext_en, q.mode[MODE_STOP2]) - 4'h1;
               d.tx_st  = TX_ASYNC;
               d.txd    = 1'b0;
            end
         end else if (q.tx_st != TX_IDLE) begin
            d.tx_st           = TX_IDLE;
            d.txd             = 1'b1;
            d.stat[ST_TX_END] = 1'b1;
         end
      end
      if (!q.ctrl[CTRL_TX_EN]) begin
         d.tx_st              = TX_IDLE;
         d.txd                = 1'b1;
         d.stat[ST_TDR_EMPTY] = 1'b1;
         d.stat[ST_TX_END]    = 1'b1;
      end

      // receiver
      rx_bits             = q.rsr;
      rx_bits[q.rx_cnt]   = q.rxd_lvl;
      rx_last             = sync_m ? SYNC_LAST : sfc_len(char7, ext_en, 1'b0) - 4'h1;
      rx_data             = sync_m ? rx_bits[7:0]
                                   : (char7 ? {1'b0, rx_bits[7:1]} : rx_bits[8:1]);
      rx_done             = 1'b0;
      case (q.rx_st)
         RX_IDLE: begin
            // a pending error stops reception until software clears it
            if (q.ctrl[CTRL_RX_ON] & ~(|q.stat[5:3])) begin
               d.rx_cnt = 4'h0;
               d.rx_ph  = 4'h0;
               if (sync_m & (ext_ck | ~q.stat[ST_RDR_FULL])) begin
                  d.rx_st = RX_SYNC;
               end else if (~sync_m & rx_fall) begin
                  d.rx_st = RX_ASYNC;
               end
            end
         end
         RX_ASYNC: begin
            if (os_tick) begin
               d.rx_ph = q.rx_ph + 4'h1;
               if (q.rx_ph == OVS_MID) begin
                  if ((q.rx_cnt == 4'h0) & q.rxd_lvl) begin
                     d.rx_st = RX_IDLE;
                  end else begin
                     d.rsr    = rx_bits;
                     d.rx_cnt = q.rx_cnt + 4'h1;
                     rx_done  = (q.rx_cnt == rx_last);
                  end
               end
            end
         end
         RX_SYNC: begin
            if (s_rise) begin
               d.rsr    = rx_bits;
               d.rx_cnt = q.rx_cnt + 4'h1;
               rx_done  = (q.rx_cnt == rx_last);
            end
         end
         default: d.rx_st = RX_IDLE;
      endcase
      if (rx_done) begin
         d.rx_st = RX_IDLE;
         if (q.stat[ST_RDR_FULL]) begin
            d.stat[ST_OVERRUN] = 1'b1;
         end else begin
            d.rdr = rx_data;
            if (!sync_m) begin
               d.stat[ST_FRAMING]  = ~rx_bits[rx_last];
               d.stat[ST_PARITY]   = q.mode[MODE_PAR_EN] & ~q.mode[MODE_MP] &
                  (rx_bits[char7 ? 4'h8 : 4'h9] !=
                   sfc_parity(rx_data, char7, q.mode[MODE_ODD]));
               d.stat[ST_RX_MPB]   = q.mode[MODE_MP] & rx_bits[char7 ? 4'h8 : 4'h9];
               d.stat[ST_BREAK]    = ~rx_bits[rx_last] & (rx_data == 8'h00);
            end
            d.stat[ST_RDR_FULL] = sync_m | (rx_bits[rx_last] & ~d.stat[ST_PARITY]);
         end
      end
      if (!q.ctrl[CTRL_RX_ON]) begin
         d.rx_st = RX_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q                    <= '0;
         q.mode               <= MODE_RST;
         q.ctrl               <= CTRL_RST;
         q.rate               <= RATE_RST;
         q.stat[ST_TDR_EMPTY] <= 1'b1;
         q.stat[ST_TX_END]    <= 1'b1;
         q.sck_lvl            <= 1'b1;
         q.rxd_lvl            <= 1'b1;
         q.sck_int            <= 1'b1;
         q.txd                <= 1'b1;
         q.sck_o              <= 1'b1;
         q.sck_oe_n           <= 1'b1;
         q.tx_st              <= TX_IDLE;
         q.rx_st              <= RX_IDLE;
      end else begin
         q <= d;
      end
   end

   assign rd_data_o         = q.rdata;
   assign link.dev_txd      = q.txd;
   assign link.dev_sck      = q.sck_o;
   assign link.dev_sck_oe_n = q.sck_oe_n;

endmodule : sfc_unit

// ==== hw/sfc_partner.sv ====
module sfc_partner
   import sfc_pkg::*;
(
   // system
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   // format and clocking
   input  wire logic       sync_i,
   input  wire logic       char7_i,
   input  wire logic       par_en_i,
   input  wire logic       odd_i,
   input  wire logic       mp_i,
   input  wire logic       stop2_i,
   input  wire logic       drive_clk_i,
   input  wire logic [7:0] div_i,
   // transmit request
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_ext_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // received character
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   output logic            rx_err_o,
   // serial link
   sfc_link_if.partner     link
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  div;
      logic        sck;
      logic [2:0]  s_sync;
      logic        s_lvl;
      logic [2:0]  r_sync;
      logic        r_lvl;
      logic [3:0]  phase;
      logic        tx_busy;
      logic [11:0] tsr;
      logic [3:0]  tx_cnt;
      logic        rx_busy;
      logic [11:0] rsr;
      logic [3:0]  rx_cnt;
      logic [3:0]  rx_ph;
      logic        txd;
      logic [7:0]  rx_data;
      logic        rx_valid;
      logic        rx_err;
   } sfc_par_state_type;

   sfc_par_state_type q;
   sfc_par_state_type d;

   logic        ext_en;
   logic        p_ext;
   logic        tog;
   logic        rise;
   logic        fall;
   logic        bit_end;
   logic [3:0]  last;
   logic [11:0] bits;

   always_comb begin
      d          = q;
      d.rx_valid = 1'b0;
      ext_en     = (mp_i | par_en_i) & ~sync_i;
      p_ext      = mp_i ? tx_ext_i : sfc_parity(tx_data_i, char7_i, odd_i);
      // own clock: free running, 16x in async, bit clock in sync
      tog        = (q.div == div_i);
      d.div      = tog ? 8'h00 : q.div + 8'h01;
      // keeps running when not driven out: it is also the local 16x timebase
      d.sck      = tog ? ~q.sck : q.sck;
      d.s_sync   = {q.s_sync[1:0], link.sck};
      d.r_sync   = {q.r_sync[1:0], link.dev_txd};
      if (q.s_sync[2] == q.s_sync[1]) begin
         d.s_lvl = q.s_sync[2];
      end
      if (q.r_sync[2] == q.r_sync[1]) begin
         d.r_lvl = q.r_sync[2];
      end
      if (drive_clk_i | ~sync_i) begin
         rise = tog & ~q.sck;
         fall = tog & q.sck & sync_i;
      end else begin
         rise = (q.s_sync[2] == q.s_sync[1]) & q.s_sync[2] & ~q.s_lvl;
         fall = (q.s_sync[2] == q.s_sync[1]) & ~q.s_sync[2] & q.s_lvl;
      end
      bit_end = rise & ~sync_i & (q.phase == OVS_LAST);
      if (rise & ~sync_i) begin
         d.phase = q.phase + 4'h1;
      end

      // transmitter
      if (!q.tx_busy) begin
         d.txd = 1'b1;
         if (tx_valid_i & (sync_i | bit_end)) begin
            d.tx_busy = 1'b1;
            d.tsr     = sync_i ? {4'hF, tx_data_i}
                               : sfc_frame(tx_data_i, char7_i, ext_en, p_ext);
            d.tx_cnt  = sync_i ? SYNC_LAST : sfc_len(char7_i, ext_en, stop2_i) - 4'h1;
            d.txd     = sync_i ? tx_data_i[0] : 1'b0;
         end
      end else if ((sync_i ? rise : bit_end) & (q.tx_cnt == 4'h0)) begin
         d.tx_busy = 1'b0;
         d.txd     = 1'b1;
      end else if (sync_i ? rise : bit_end) begin
         d.tx_cnt  = q.tx_cnt - 4'h1;
         if (!sync_i) begin
            d.tsr  = {1'b1, q.tsr[11:1]};
            d.txd  = q.tsr[1];
         end
      end else if (fall & (q.tx_cnt != SYNC_LAST)) begin
         // bit 0 stays on the line for the first rise
         d.tsr     = {1'b1, q.tsr[11:1]};
         d.txd     = q.tsr[1];
      end

      // receiver
      last         = sync_i ? SYNC_LAST : sfc_len(char7_i, ext_en, 1'b0) - 4'h1;
      bits         = q.rsr;
      bits[q.rx_cnt] = q.r_lvl;
      if (!q.rx_busy) begin
         d.rx_cnt = 4'h0;
         d.rx_ph  = 4'h0;
         d.rx_busy = sync_i | ((q.r_sync[2] == q.r_sync[1]) & ~q.r_sync[2] & q.r_lvl);
      end else if (sync_i ? rise : (rise & (q.rx_ph == OVS_MID))) begin
         d.rsr    = bits;
         d.rx_cnt = q.rx_cnt + 4'h1;
         if ((q.rx_cnt == 4'h0) & q.r_lvl & ~sync_i) begin
            d.rx_busy = 1'b0;
         end else if (q.rx_cnt == last) begin
            d.rx_busy  = 1'b0;
            d.rx_valid = 1'b1;
            d.rx_data  = sync_i ? bits[7:0]
                                : (char7_i ? {1'b0, bits[7:1]} : bits[8:1]);
            d.rx_err   = ~sync_i & ~bits[last];
         end
      end
      if (q.rx_busy & rise & ~sync_i) begin
         d.rx_ph = q.rx_ph + 4'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q       <= '0;
         q.sck   <= 1'b1;
         q.s_lvl <= 1'b1;
         q.r_lvl <= 1'b1;
         q.txd   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign tx_ready_o        = ~q.tx_busy;
   assign rx_data_o         = q.rx_data;
   assign rx_valid_o        = q.rx_valid;
   assign rx_err_o          = q.rx_err;
   assign link.par_txd      = q.txd;
   assign link.par_sck      = q.sck;
   assign link.par_sck_oe_n = ~drive_clk_i;

endmodule : sfc_partner

// ==== verification/sfc_props.sv ====
module sfc_props (
   // system
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // link
   input wire logic dev_txd,
   input wire logic dev_sck,
   input wire logic dev_sck_oe_n,
   input wire logic par_txd,
   input wire logic par_sck_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_out;
      $fell(sys_rst_i);
   endsequence
   // shortest legal bit, a sync bit at the fastest rate, is four clocks long
   sequence s_low;
      !dev_txd [*3];
   endsequence
   a_rst_txd_idle: assert property (s_out |-> dev_txd)
      else $error("device line not idle");
   a_rst_sck_high: assert property (s_out |-> dev_sck)
      else $error("device clock not high");
   a_rst_sck_free: assert property (s_out |-> dev_sck_oe_n)
      else $error("device clock driven");
   a_rst_par_idle: assert property (s_out |-> par_txd)
      else $error("partner line not idle");
   a_no_pin_fight: assert property (dev_sck_oe_n || par_sck_oe_n)
      else $error("clock pin driven twice");
   a_start_hold: assert property ($fell(dev_txd) |=> s_low)
      else $error("start bit too short");
   a_sck_half_min: assert property ($changed(dev_sck) |=> $stable(dev_sck))
      else $error("clock half period too short");
   a_sck_rise_mid: assert property ($rose(dev_sck) && !dev_sck_oe_n |-> $stable(dev_txd))
      else $error("data moved at clock rise");
endmodule : sfc_props

// ==== verification/tb_top.sv ====
module tb_top
   import sfc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MODES [7] = '{8'h00, 8'h08, 8'h30, 8'h60, 8'h04, 8'h00, 8'h80};
   localparam logic [7:0] RST_V [8] = '{MODE_RST, CTRL_RST, RATE_RST, 8'h00, 8'h00, 8'h00,
                                        8'h84, 8'h00};
   logic       clock_i = 1'b0, sys_rst_i = 1'b1;
   logic       wen = 1'b0, ren = 1'b0, pval = 1'b0, pdrv = 1'b0, prdy, pvalid;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdat = 8'h00, pdat = 8'h00, pfmt = 8'h00, rdat, prx, sbuf;
   int         n_mismatch = 0, samples_checked = 0;
   sfc_link_if lnk ();
   sfc_unit u_sfc_unit (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
      .wr_data_i(wdat), .wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdat), .link(lnk));
   sfc_partner u_sfc_partner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sync_i(pfmt[7]),
      .char7_i(pfmt[6]), .par_en_i(pfmt[5]), .odd_i(pfmt[4]), .mp_i(pfmt[2]), .stop2_i(pfmt[3]),
      .drive_clk_i(pdrv), .div_i(8'h03), .tx_data_i(pdat), .tx_ext_i(pfmt[2]), .tx_valid_i(pval),
      .tx_ready_o(prdy), .rx_data_o(prx), .rx_valid_o(pvalid), .rx_err_o(), .link(lnk));
   sfc_props u_sfc_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .dev_txd(lnk.dev_txd),
      .dev_sck(lnk.dev_sck), .dev_sck_oe_n(lnk.dev_sck_oe_n), .par_txd(lnk.par_txd),
      .par_sck_oe_n(lnk.par_sck_oe_n));
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdat <= d;
      wen <= 1'b1;
      @(posedge clock_i);
      wen <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      ren <= 1'b1;
      @(posedge clock_i);
      ren <= 1'b0;
      #1 d = rdat;
   endtask : rd
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic psend(input logic [7:0] d);
      @(posedge clock_i);
      pdat <= d;
      pval <= 1'b1;
      // the partner only starts at its own bit boundary, up to one bit later
      for (int k = 0; k < 300 && prdy !== 1'b0; k++) @(posedge clock_i) #1;
      @(posedge clock_i);
      pval <= 1'b0;
   endtask : psend
   // a status read costs two cycles, so the bound covers a slow frame
   task automatic poll(input int b);
      sbuf = 8'h00;
      for (int k = 0; k < 2000 && sbuf[b] !== 1'b1; k++) rd(ADDR_STATUS, sbuf);
   endtask : poll
   task automatic t_reset;
      wr(3'h7, 8'hFF);
      for (int a = 0; a < 8; a++) begin
         if (a != 4 && a != 5) begin
            rd(3'(a), sbuf);
            chk(sbuf, RST_V[a]);
         end
      end
      $display("reset done");
   endtask : t_reset
   task automatic t_fmt(input int i);
      logic [7:0] m;
      logic [7:0] msk;
      logic [7:0] d;
      logic [7:0] c;
      m = MODES[i];
      c = m[MODE_SYNC] ? 8'h20 : 8'h30;
      c = (i == 5) ? 8'h32 : ((i == 0) ? 8'h31 : c);
      msk = m[MODE_CHAR7] ? 8'h7F : 8'hFF;
      d = 8'hA5 ^ 8'(i);
      // clock drive changes first, so the pin settles before the external clock mode watches it
      @(posedge clock_i);
      pdrv <= (i == 5);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_RATE, 8'h03);
      wr(ADDR_MODE, m);
      pfmt <= m;
      wr(ADDR_CTRL, c);
      wr(ADDR_TXDATA, d);
      for (int k = 0; k < 4000 && pvalid !== 1'b1; k++) @(posedge clock_i) #1;
      chk(prx & msk, d & msk);
      if (!m[MODE_SYNC]) begin
         psend(~d);
         poll(ST_RDR_FULL);
         chk(sbuf, 8'hC4 | (m[MODE_MP] ? 8'h02 : 8'h00));
         rd(ADDR_RXDATA, sbuf);
         chk(sbuf & msk, ~d & msk);
         wr(ADDR_STATUS, 8'h00);
      end
      $display("format %h done", m);
   endtask : t_fmt
   // eight zero bits into a seven bit receiver put a low stop bit on the line
   task automatic t_break;
      @(posedge clock_i);
      pfmt <= 8'h00;
      pdrv <= 1'b0;
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_MODE, 8'h40);
      wr(ADDR_CTRL, 8'h30);
      psend(8'h00);
      poll(ST_FRAMING);
      chk(sbuf, 8'h95);
      $display("break done");
   endtask : t_break
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      #1500000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (4) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_reset;
      for (int i = 0; i < 7; i++) t_fmt(i);
      t_break;
      end_sim;
   end
endmodule : tb_top
